// >>> hdl/crb_pkg.sv
// crb_pkg: constants, register map and types of the capture record builder
package crb_pkg;
  localparam int PTR_W = 28;
  localparam int MB_SHIFT = 20;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_SLEN = 5'h04;
  localparam logic [4:0] REG_MEM = 5'h08;
  localparam logic [4:0] REG_RDPTR = 5'h0c;
  localparam logic [4:0] REG_WRPTR = 5'h10;
  localparam logic [4:0] REG_STAT = 5'h14;
  localparam int CTRL_VARLEN = 0;
  localparam int CTRL_ALIGN8 = 1;
  localparam int CTRL_PEN = 2;
  localparam int CTRL_DEFAULTS = 4;
  localparam logic [13:0] SLEN_DEF = 14'h0030;
  localparam logic [13:0] SLEN_MIN = 14'h0020;
  localparam logic [13:0] SLEN_MAX = 14'h2800;
  localparam logic [13:0] SLEN_MASK = 14'h3ff8;
  localparam logic [7:0] MEM_RX_DEF = 8'h70;
  localparam logic [7:0] MEM_TX_DEF = 8'h10;
  localparam logic [4:0] HDR_LEN = 5'h12;
  localparam logic [4:0] AREA4 = 5'h14;
  localparam logic [4:0] AREA8 = 5'h18;
  localparam logic [4:0] TX_AREA = 5'h18;
  localparam logic [14:0] MASK4 = 15'h0003;
  localparam logic [14:0] MASK8 = 15'h0007;
  localparam logic [4:0] HB_RLEN = 5'h00;
  localparam logic [4:0] HB_LCTR = 5'h02;
  localparam logic [4:0] HB_PORT = 5'h04;
  localparam logic [4:0] HB_FLAGS = 5'h05;
  localparam logic [4:0] HB_WLEN = 5'h06;
  typedef struct packed {
    logic varlen;
    logic eight_byte_alignment;
    logic [1:0] port_en;
  } crb_cfg_t;
  localparam crb_cfg_t CFG_DEF = '{varlen: 1'b1, eight_byte_alignment: 1'b0, port_en: 2'h3};
  typedef struct packed {logic valid; logic last; logic port; logic [7:0] data;} crb_rx_t;
  typedef struct packed {logic valid; logic last; logic [7:0] data;} crb_byte_t;
  typedef struct packed {logic we; logic [PTR_W-1:0] addr; logic [7:0] data;} crb_hmw_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_PAY = 3'h1, RX_PAD = 3'h3, RX_HDR = 3'h2, RX_DROP = 3'h6
  } crb_rx_st_t;
  typedef enum logic [1:0] {TX_HDR = 2'h0, TX_PAY = 2'h1, TX_SKIP = 2'h3} crb_tx_st_t;
endpackage : crb_pkg

// >>> hdl/crb_top.sv
// crb_top: capture record builder with replay path and avalon register slave
`timescale 1ns/100ps
module crb_top (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [4:0] AV_ADDRESS,
  input wire logic AV_READ,
  input wire logic AV_WRITE,
  input wire logic [31:0] AV_WRITEDATA,
  output logic [31:0] AV_READDATA,
  output logic AV_WAITREQUEST,
  input wire crb_pkg::crb_rx_t RX_IN,
  output logic RX_READY,
  output crb_pkg::crb_hmw_t HM_WR,
  output logic CAPTURE_ACTIVE,
  input wire crb_pkg::crb_byte_t TXS_IN,
  output logic TXS_READY,
  output crb_pkg::crb_byte_t TX_OUT
);
  localparam int PW = crb_pkg::PTR_W;

  crb_pkg::crb_cfg_t cfg;
  logic [13:0] slen;
  logic [13:0] next_slen;
  logic [7:0] mem_rx;
  logic [7:0] mem_tx;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_ptr;
  logic [31:0] next_rdata;
  logic wr_en;

  crb_pkg::crb_rx_st_t rx_st;
  logic [14:0] cnt;
  logic [15:0] wlen;
  logic [13:0] lim;
  logic vmode;
  logic a8;
  logic rport;
  logic trunc;
  logic [4:0] hidx;
  logic [15:0] lctr;
  logic discarding;
  logic rx_take;

  crb_pkg::crb_tx_st_t tx_st;
  logic [4:0] tidx;
  logic [15:0] twlen;
  logic [15:0] tcnt;
  logic tx_take;

  logic [PW-1:0] buf_size;
  logic [PW-1:0] used;
  logic [PW-1:0] need;
  logic space_ok;
  logic [4:0] r_area;
  logic [14:0] mask;
  logic [14:0] pad_target;
  logic [15:0] rlen;
  logic [PW-1:0] off_pay;
  logic [PW-1:0] rec_len;
  logic [7:0] hbyte;

  // pointers wrap at the receive allocation, which need not be a power of two
  function automatic logic [PW-1:0] wrap_add(
    input logic [PW-1:0] base,
    input logic [PW-1:0] off,
    input logic [PW-1:0] size
  );
    logic [PW:0] s;
    s = {1'b0, base} + {1'b0, off};
    if (s >= {1'b0, size}) begin
      s = s - {1'b0, size};
    end
    return s[PW-1:0];
  endfunction : wrap_add

  // register slave: one wait cycle, then the transfer completes
  // readdata is a plain register, loaded during the wait cycle

  assign wr_en = AV_WRITE && !AV_WAITREQUEST;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      AV_WAITREQUEST <= 1'b1;
    end else if ((AV_READ || AV_WRITE) && AV_WAITREQUEST) begin
      AV_WAITREQUEST <= 1'b0;
    end else begin
      AV_WAITREQUEST <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      AV_READDATA <= 32'h0;
    end else if (AV_READ && AV_WAITREQUEST) begin
      AV_READDATA <= next_rdata;
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    if (AV_ADDRESS == crb_pkg::REG_CTRL) begin
      next_rdata = {28'h0, cfg.port_en, cfg.eight_byte_alignment, cfg.varlen};
    end else if (AV_ADDRESS == crb_pkg::REG_SLEN) begin
      next_rdata = {18'h0, slen};
    end else if (AV_ADDRESS == crb_pkg::REG_MEM) begin
      next_rdata = {16'h0, mem_tx, mem_rx};
    end else if (AV_ADDRESS == crb_pkg::REG_RDPTR) begin
      next_rdata = {{(32-PW){1'b0}}, rd_ptr};
    end else if (AV_ADDRESS == crb_pkg::REG_WRPTR) begin
      next_rdata = {{(32-PW){1'b0}}, wr_ptr};
    end else if (AV_ADDRESS == crb_pkg::REG_STAT) begin
      next_rdata = {lctr, 12'h0, discarding, rx_st != crb_pkg::RX_IDLE,
                    tx_st != crb_pkg::TX_HDR, CAPTURE_ACTIVE};
    end
  end

  // out of range values clamp rather than fault, so software never sees an error
  always_comb begin
    next_slen = crb_pkg::SLEN_MAX;
    if (AV_WRITEDATA[31:16] == 16'h0 && AV_WRITEDATA[15:0] <= {2'h0, crb_pkg::SLEN_MAX}) begin
      next_slen = AV_WRITEDATA[13:0];
    end
    if (next_slen < crb_pkg::SLEN_MIN) begin
      next_slen = crb_pkg::SLEN_MIN;
    end
    next_slen = next_slen & crb_pkg::SLEN_MASK;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg <= crb_pkg::CFG_DEF;
      slen <= crb_pkg::SLEN_DEF;
      mem_rx <= crb_pkg::MEM_RX_DEF;
      mem_tx <= crb_pkg::MEM_TX_DEF;
    end else if (wr_en) begin
      if (AV_ADDRESS == crb_pkg::REG_CTRL) begin
        if (AV_WRITEDATA[crb_pkg::CTRL_DEFAULTS]) begin
          cfg <= crb_pkg::CFG_DEF;
          slen <= crb_pkg::SLEN_DEF;
          mem_rx <= crb_pkg::MEM_RX_DEF;
          mem_tx <= crb_pkg::MEM_TX_DEF;
        end else begin
          cfg.varlen <= AV_WRITEDATA[crb_pkg::CTRL_VARLEN];
          cfg.eight_byte_alignment <= AV_WRITEDATA[crb_pkg::CTRL_ALIGN8];
          cfg.port_en <= AV_WRITEDATA[crb_pkg::CTRL_PEN +: 2];
        end
      end else if (AV_ADDRESS == crb_pkg::REG_SLEN) begin
        slen <= next_slen;
      end else if (AV_ADDRESS == crb_pkg::REG_MEM) begin
        // applied at once; the host keeps both streams idle meanwhile
        mem_rx <= AV_WRITEDATA[7:0];
        mem_tx <= AV_WRITEDATA[15:8];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_ptr <= '0;
    end else if (wr_en && AV_ADDRESS == crb_pkg::REG_RDPTR) begin
      // trusted as is: software only moves it forward over consumed records
      rd_ptr <= AV_WRITEDATA[PW-1:0];
    end
  end

  // receive buffer space, measured in bytes of stream 0

  assign buf_size = {mem_rx, {crb_pkg::MB_SHIFT{1'b0}}};
  assign used = (wr_ptr >= rd_ptr) ? wr_ptr - rd_ptr : wr_ptr + buf_size - rd_ptr;
  // reserve a worst case record so no record can overrun unread data
  assign need = {{(PW-5){1'b0}}, (cfg.eight_byte_alignment ? crb_pkg::AREA8 : crb_pkg::AREA4)}
              + {{(PW-14){1'b0}}, slen};
  // strictly less: a completely full buffer would otherwise read as empty
  assign space_ok = (used + need) < buf_size;

  assign r_area = a8 ? crb_pkg::AREA8 : crb_pkg::AREA4;
  assign mask = a8 ? crb_pkg::MASK8 : crb_pkg::MASK4;
  assign pad_target = vmode ? ((cnt + mask) & ~mask) : {1'b0, lim};
  assign rlen = {11'h0, r_area} + {1'b0, cnt};
  assign off_pay = {{(PW-5){1'b0}}, r_area} + {{(PW-15){1'b0}}, cnt};
  assign rec_len = {{(PW-16){1'b0}}, rlen};
  assign rx_take = RX_IN.valid && RX_READY;

  always_comb begin
    case (hidx)
      crb_pkg::HB_RLEN: hbyte = rlen[15:8];
      crb_pkg::HB_RLEN + 5'h01: hbyte = rlen[7:0];
      crb_pkg::HB_LCTR: hbyte = lctr[15:8];
      crb_pkg::HB_LCTR + 5'h01: hbyte = lctr[7:0];
      crb_pkg::HB_PORT: hbyte = {7'h0, rport};
      crb_pkg::HB_FLAGS: hbyte = {5'h0, a8, ~vmode, trunc};
      crb_pkg::HB_WLEN: hbyte = wlen[15:8];
      crb_pkg::HB_WLEN + 5'h01: hbyte = wlen[7:0];
      default: hbyte = 8'h00; // header tail and alignment pad
    endcase
  end

  // payload first, header last: its length and loss fields are known by then
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_st <= crb_pkg::RX_IDLE;
      RX_READY <= 1'b0;
      cnt <= '0;
      wlen <= '0;
      lim <= crb_pkg::SLEN_DEF;
      vmode <= 1'b1;
      a8 <= 1'b0;
      rport <= 1'b0;
      trunc <= 1'b0;
      hidx <= '0;
      lctr <= '0;
      discarding <= 1'b0;
      wr_ptr <= '0;
      HM_WR <= '0;
    end else begin
      HM_WR.we <= 1'b0;
      case (rx_st)
        crb_pkg::RX_IDLE: begin
          if (RX_IN.valid) begin
            RX_READY <= 1'b1;
            if (!cfg.port_en[RX_IN.port]) begin
              rx_st <= crb_pkg::RX_DROP;
            end else if (!space_ok) begin
              rx_st <= crb_pkg::RX_DROP;
              discarding <= 1'b1;
              // saturates, so a long loss never reads back as a small one
              if (lctr != 16'hffff) begin
                lctr <= lctr + 16'h0001;
              end
            end else begin
              rx_st <= crb_pkg::RX_PAY;
              discarding <= 1'b0;
              // settings are frozen per record so a write mid packet is harmless
              lim <= slen;
              vmode <= cfg.varlen;
              a8 <= cfg.eight_byte_alignment;
              rport <= RX_IN.port;
              cnt <= '0;
              wlen <= '0;
              trunc <= 1'b0;
            end
          end
        end
        crb_pkg::RX_PAY: begin
          if (rx_take) begin
            if (wlen != 16'hffff) begin
              wlen <= wlen + 16'h0001;
            end
            if (cnt < {1'b0, lim}) begin
              HM_WR.we <= 1'b1;
              HM_WR.addr <= wrap_add(wr_ptr, off_pay, buf_size);
              HM_WR.data <= RX_IN.data;
              cnt <= cnt + 15'h0001;
            end else begin
              trunc <= 1'b1;
            end
            if (RX_IN.last) begin
              RX_READY <= 1'b0;
              rx_st <= crb_pkg::RX_PAD;
            end
          end
        end
        crb_pkg::RX_PAD: begin
          if (cnt < pad_target) begin
            HM_WR.we <= 1'b1;
            HM_WR.addr <= wrap_add(wr_ptr, off_pay, buf_size);
            HM_WR.data <= 8'h00;
            cnt <= cnt + 15'h0001;
          end else begin
            rx_st <= crb_pkg::RX_HDR;
            hidx <= '0;
          end
        end
        crb_pkg::RX_HDR: begin
          HM_WR.we <= 1'b1;
          HM_WR.addr <= wrap_add(wr_ptr, {{(PW-5){1'b0}}, hidx}, buf_size);
          HM_WR.data <= hbyte;
          hidx <= hidx + 5'h01;
          if (hidx == r_area - 5'h01) begin
            wr_ptr <= wrap_add(wr_ptr, rec_len, buf_size);
            lctr <= '0;
            rx_st <= crb_pkg::RX_IDLE;
          end
        end
        crb_pkg::RX_DROP: begin
          // bytes are drained so the source never stalls on a refused packet
          if (rx_take && RX_IN.last) begin
            RX_READY <= 1'b0;
            rx_st <= crb_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_st <= crb_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // led follows the last admission decision, so it flickers near full
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CAPTURE_ACTIVE <= 1'b0;
    end else begin
      CAPTURE_ACTIVE <= (|cfg.port_en) && !discarding;
    end
  end

  // replay path: own state, shares nothing with capture but the registers

  // no pacing counter: replay bytes leave as fast as the host offers them
  assign tx_take = TXS_IN.valid && TXS_READY;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TXS_READY <= 1'b0;
    end else begin
      TXS_READY <= mem_tx != 8'h00;
    end
  end

  // only host bytes reach the line; there is no reply generator
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_st <= crb_pkg::TX_HDR;
      tidx <= '0;
      twlen <= '0;
      tcnt <= '0;
      TX_OUT <= '0;
    end else begin
      TX_OUT.valid <= 1'b0;
      TX_OUT.last <= 1'b0;
      if (tx_take) begin
        case (tx_st)
          crb_pkg::TX_HDR: begin
            tidx <= tidx + 5'h01;
            if (tidx == crb_pkg::HB_WLEN) begin
              twlen[15:8] <= TXS_IN.data;
            end
            if (tidx == crb_pkg::HB_WLEN + 5'h01) begin
              twlen[7:0] <= TXS_IN.data;
            end
            // header area is fixed at eight byte alignment
            if (tidx == crb_pkg::TX_AREA - 5'h01) begin
              tcnt <= '0;
              tx_st <= (twlen == 16'h0) ? crb_pkg::TX_SKIP : crb_pkg::TX_PAY;
            end
          end
          crb_pkg::TX_PAY: begin
            TX_OUT.valid <= 1'b1;
            TX_OUT.data <= TXS_IN.data;
            tcnt <= tcnt + 16'h0001;
            if (tcnt == twlen - 16'h0001) begin
              TX_OUT.last <= 1'b1;
              tx_st <= crb_pkg::TX_SKIP;
            end
          end
          default: begin
            tx_st <= crb_pkg::TX_SKIP;
          end
        endcase
        if (TXS_IN.last) begin
          tx_st <= crb_pkg::TX_HDR;
          tidx <= '0;
          if (tx_st == crb_pkg::TX_PAY) begin
            TX_OUT.last <= 1'b1;
          end
        end
      end
    end
  end

endmodule : crb_top

// >>> tb/crb_top_props.sv
// port checker for the capture record builder
`timescale 1ns/100ps
module crb_top_props (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [4:0] AV_ADDRESS,
  input wire logic AV_READ,
  input wire logic AV_WRITE,
  input wire logic [31:0] AV_WRITEDATA,
  input wire logic [31:0] AV_READDATA,
  input wire logic AV_WAITREQUEST,
  input wire crb_pkg::crb_rx_t RX_IN,
  input wire logic RX_READY,
  input wire crb_pkg::crb_hmw_t HM_WR,
  input wire logic CAPTURE_ACTIVE,
  input wire crb_pkg::crb_byte_t TXS_IN,
  input wire logic TXS_READY,
  input wire crb_pkg::crb_byte_t TX_OUT
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  property p_wait_one;
    !AV_WAITREQUEST |=> AV_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_answer;
    (AV_READ || AV_WRITE) && AV_WAITREQUEST |=> !AV_WAITREQUEST;
  endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_rd_hold;
    !$past(AV_READ) |-> $stable(AV_READDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_tx_src;
    TX_OUT.valid |-> $past(TXS_READY) && $past(TXS_IN.valid) && TX_OUT.data == $past(TXS_IN.data);
  endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx byte not supplied");
  // a register write may change the allocation, so skip around it
  property p_tx_ready;
    TXS_READY && !AV_WRITE && !$past(AV_WRITE) |=> TXS_READY;
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("tx stalled");
  property p_rx_data;
    HM_WR.we && $past(RX_READY) && $past(RX_IN.valid)
      |-> HM_WR.data == $past(RX_IN.data);
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("payload byte wrong");
  property p_ca_fall;
    $fell(CAPTURE_ACTIVE) |-> $past(RX_READY) || !$past(AV_WAITREQUEST) ||
      !$past(AV_WAITREQUEST, 2);
  endproperty
  a_ca_fall: assert property (p_ca_fall) else $error("indicator fell idle");
  property p_align;
    $rose(RX_READY) ##1 HM_WR.we |-> HM_WR.addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("payload misaligned");
  c_write: cover property (AV_WRITE && !AV_WAITREQUEST);
  c_ca_off: cover property ($fell(CAPTURE_ACTIVE));
  c_tx_last: cover property (TX_OUT.valid && TX_OUT.last);
endmodule : crb_top_props
bind crb_top crb_top_props crb_top_props_i (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
  .AV_ADDRESS(AV_ADDRESS), .AV_READ(AV_READ), .AV_WRITE(AV_WRITE),
  .AV_WRITEDATA(AV_WRITEDATA), .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST),
  .RX_IN(RX_IN), .RX_READY(RX_READY), .HM_WR(HM_WR), .CAPTURE_ACTIVE(CAPTURE_ACTIVE),
  .TXS_IN(TXS_IN), .TXS_READY(TXS_READY), .TX_OUT(TX_OUT));

// >>> tb/crb_host_mem.sv
// host memory model: byte store of the receive stream buffer
`timescale 1ns/100ps
module crb_host_mem (
  input wire logic clk,
  input wire crb_pkg::crb_hmw_t hm
);
  // only the low 4 KB are kept; the bench records stay below that
  logic [7:0] mem [0:4095];
  always @(posedge clk) begin
    if (hm.we === 1'b1) begin
      mem[hm.addr[11:0]] <= hm.data;
    end
  end
endmodule : crb_host_mem

// >>> tb/tb.sv
// self-checking bench for the capture record builder
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic [4:0] a; logic [31:0] d; logic [31:0] e;} crb_row_t;
  logic clk;
  logic rst_b;
  logic [4:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic wt;
  logic [31:0] q;
  crb_pkg::crb_rx_t rx;
  logic rx_rdy;
  crb_pkg::crb_hmw_t hm;
  logic cap;
  crb_pkg::crb_byte_t txs;
  logic txs_rdy;
  crb_pkg::crb_byte_t tx;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] txq[$];
  int txc[$];
  logic txl[$];
  crb_row_t rows [9] = '{
    '{5'h04, 32'h10, 32'h20}, '{5'h04, 32'h10000, 32'h2800},
    '{5'h04, 32'h65, 32'h60}, '{5'h04, 32'h27ff, 32'h27f8},
    '{5'h00, 32'h3, 32'h3}, '{5'h08, 32'h830, 32'h830},
    '{5'h18, 32'hffffffff, 32'h0}, '{5'h10, 32'h40, 32'h0},
    '{5'h00, 32'h10, 32'hd}};
  crb_top crb_top_i (.CORE_CLK(clk), .RST_B(rst_b), .AV_ADDRESS(adr), .AV_READ(rd),
    .AV_WRITE(wr), .AV_WRITEDATA(wd), .AV_READDATA(rdat), .AV_WAITREQUEST(wt),
    .RX_IN(rx), .RX_READY(rx_rdy), .HM_WR(hm), .CAPTURE_ACTIVE(cap),
    .TXS_IN(txs), .TXS_READY(txs_rdy), .TX_OUT(tx));
  crb_host_mem crb_host_mem_i (.clk(clk), .hm(hm));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx.valid === 1'b1) begin
      txq.push_back(tx.data);
      txc.push_back(cyc);
      txl.push_back(tx.last);
    end
  end
  task automatic stop_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic fail();
    err_total++;
    $display("BAD %0t timeout", $time);
    stop_test();
  endtask : fail
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) fail();
    end while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  function automatic logic [31:0] mb(input int a);
    return {24'h0, crb_host_mem_i.mem[a]};
  endfunction : mb
  function automatic logic [31:0] hw(input int a);
    return {16'h0, crb_host_mem_i.mem[a], crb_host_mem_i.mem[a + 1]};
  endfunction : hw
  // send a packet, then wait until the record writes have gone quiet
  task automatic pkt(input logic p, input int n, input logic [7:0] b);
    int i;
    int t;
    i = 0;
    t = 0;
    @(posedge clk);
    rx <= {1'b1, n == 1, p, b};
    while (i < n) begin
      @(posedge clk);
      t++;
      if (t > 3000) fail();
      if (rx_rdy === 1'b1) begin
        i++;
        rx <= {i < n, i == n - 1, p, b + 8'(i)};
      end
    end
    t = 0;
    i = 0;
    while (t < 6) begin
      @(posedge clk);
      i++;
      t = hm.we === 1'b1 ? 0 : t + 1;
      if (i > 3000) fail();
    end
  endtask : pkt
  task automatic txr(input int w, input logic [7:0] b);
    int i;
    int t;
    int n;
    n = 24 + (w + 7) / 8 * 8;
    // type bytes zero, the one link type in use; payload kept as captured
    i = 0;
    t = 0;
    @(posedge clk);
    txs <= {1'b1, 1'b0, 8'h0};
    while (i < n) begin
      @(posedge clk);
      t++;
      if (t > 500) fail();
      if (txs_rdy === 1'b1) begin
        i++;
        txs <= {i < n, i == n - 1, i == 7 ? 8'(w) : (i >= 24 ? b + 8'(i - 24) : 8'h0)};
      end
    end
  endtask : txr
  initial begin
    rst_b = 1'b0;
    adr = 5'h0;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    rx = '0;
    txs = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, 5'h00, 32'h0);
    chk(q, 32'hd);
    bus(1'b0, 5'h04, 32'h0);
    chk(q, 32'h30);
    bus(1'b0, 5'h08, 32'h0);
    chk(q, 32'h1070);
    chk({31'h0, cap}, 32'h1);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].e);
    end
    bus(1'b0, 5'h04, 32'h0);
    chk(q, 32'h30);
    pkt(1'b0, 5, 8'h10);
    bus(1'b0, 5'h10, 32'h0);
    chk(q, 32'd28);
    chk(hw(0), 32'd28);
    chk(hw(6), 32'd5);
    chk({31'h0, rx_rdy}, 32'h0);
    for (int k = 0; k < 8; k++) begin
      chk(mb(20 + k), k < 5 ? 32'h10 + k : 32'h0);
    end
    bus(1'b1, 5'h00, 32'he);
    bus(1'b1, 5'h04, 32'h20);
    pkt(1'b0, 40, 8'h50);
    pkt(1'b1, 3, 8'h90);
    bus(1'b0, 5'h10, 32'h0);
    chk(q, 32'd140);
    chk(hw(28), 32'd56);
    chk(mb(33), 32'h7);
    chk(hw(34), 32'd40);
    chk(mb(83), 32'h6f);
    chk(mb(88), 32'h1);
    chk(mb(89), 32'h6);
    chk(mb(110), 32'h92);
    chk(mb(111), 32'h0);
    chk(mb(139), 32'h0);
    bus(1'b1, 5'h00, 32'h5);
    pkt(1'b1, 4, 8'h30);
    bus(1'b0, 5'h10, 32'h0);
    chk(q, 32'd140);
    // read pointer just ahead of the write pointer: buffer looks full
    bus(1'b1, 5'h00, 32'hd);
    bus(1'b1, 5'h0c, 32'd148);
    pkt(1'b0, 4, 8'h30);
    pkt(1'b0, 4, 8'h30);
    chk({31'h0, cap}, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0002_0008);
    bus(1'b1, 5'h0c, 32'd140);
    fork
      pkt(1'b0, 4, 8'h20);
      begin
        txr(5, 8'h40);
        txr(3, 8'h80);
      end
    join
    chk({31'h0, cap}, 32'h1);
    bus(1'b0, 5'h10, 32'h0);
    chk(q, 32'd164);
    chk(hw(142), 32'h2);
    chk(32'(txq.size()), 32'd8);
    for (int k = 0; k < 8; k++) begin
      chk({24'h0, txq[k]}, k < 5 ? 32'h40 + k : 32'h7b + k);
      chk({31'h0, txl[k]}, {31'h0, k == 4 || k == 7});
      if (k > 0 && k < 5) chk(32'(txc[k] - txc[k - 1]), 32'h1);
    end
    bus(1'b1, 5'h08, 32'h70);
    repeat (2) @(posedge clk);
    chk({31'h0, txs_rdy}, 32'h0);
    // second reset in mid run: registers and pointers return to defaults
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, 5'h10, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 5'h04, 32'h0);
    chk(q, 32'h30);
    chk({30'h0, cap, txs_rdy}, 32'h3);
    stop_test();
  end
endmodule : tb
